// ---- core/nvsc_pkg.sv ----
`default_nettype none
package nvsc_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int CNT_W         = 18;

    // times as printed, in their own units
    localparam int READ_ACCESS_NS           = 45;
    localparam int WRITE_PULSE_NS           = 30;
    localparam int HW_REQUEST_PULSE_NS      = 20;
    localparam int REQUEST_TO_BUSY_NS       = 300;
    localparam int INHIBIT_RELEASE_NS       = 700;
    localparam int RECALL_DURATION_US       = 20;
    localparam int STORE_DURATION_MS        = 10;
    localparam int POWERUP_RECALL_DURATION_US = 550;

    // host waits out a device maximum, so every count rounds up
    function automatic int cycUp(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cycUp

    localparam int READ_CYC      = cycUp(READ_ACCESS_NS);
    localparam int PULSE_CYC     = cycUp(WRITE_PULSE_NS);
    localparam int REQ_MIN_CYC   = cycUp(HW_REQUEST_PULSE_NS);
    localparam int REQ_CYC       = cycUp(REQUEST_TO_BUSY_NS);
    localparam int RECOVER_CYC   = cycUp(INHIBIT_RELEASE_NS);
    localparam int RECALL_CYC    = cycUp(RECALL_DURATION_US * 1000);
    localparam int STORE_CYC     = cycUp(STORE_DURATION_MS * 1000000);
    localparam int POWERUP_CYC   = cycUp(POWERUP_RECALL_DURATION_US * 1000);
    localparam int SYNC_CYC      = 2;

    localparam logic [14:0] ADDR_RST   = 15'h0000;
    localparam logic [7:0]  DATA_RST   = 8'h00;
    localparam logic [2:0]  SEQ_LAST   = 3'h5;
    localparam logic [13:0] SEQ_ADDR0  = 14'h0E38;
    localparam logic [13:0] SEQ_ADDR1  = 14'h31C7;
    localparam logic [13:0] SEQ_ADDR2  = 14'h03E0;
    localparam logic [13:0] SEQ_ADDR3  = 14'h3C1F;
    localparam logic [13:0] SEQ_ADDR4  = 14'h303F;
    localparam logic [13:0] STORE_ADDR = 14'h0FC0;
    localparam logic [13:0] RECALL_ADDR = 14'h0C63;

    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_SW_STORE, OP_SW_RECALL, OP_HW_STORE
    } nvsc_op_type;

    typedef struct packed {
        nvsc_op_type op;
        logic [14:0] addr;
        logic [7:0]  wdata;
    } nvsc_cmd_type;

    typedef struct packed {
        logic        chipEnableN;
        logic        outputEnableN;
        logic        writeEnableN;
        logic [14:0] addressBus;
        logic [7:0]  dataBusOut;
        logic        dataBusOe;
        logic        storeBusyNOut;
        logic        storeBusyNOe;
    } nvsc_pin_type;

    localparam nvsc_pin_type PIN_RST = '{1'b1, 1'b1, 1'b1, ADDR_RST, DATA_RST,
                                         1'b0, 1'b0, 1'b0};

    function automatic logic [14:0] seqAddr(input logic [2:0] idx, input logic recall);
        logic [13:0] a;
        unique case (idx)
            3'h0: a = SEQ_ADDR0;
            3'h1: a = SEQ_ADDR1;
            3'h2: a = SEQ_ADDR2;
            3'h3: a = SEQ_ADDR3;
            3'h4: a = SEQ_ADDR4;
            default: a = recall ? RECALL_ADDR : STORE_ADDR;
        endcase
        return {1'b0, a};
    endfunction : seqAddr
endpackage : nvsc_pkg
`default_nettype wire

// ---- core/nvsc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvsc_sync #(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // pins in, synchronised out
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] stage1_ff;
    logic [W-1:0] stage2_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage1_ff <= RST_VAL;
            stage2_ff <= RST_VAL;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;
endmodule : nvsc_sync
`default_nettype wire

// ---- core/nvsc_ctrl.sv ----
// Function
// RQ1: device reads when chip and output enable low, write and busy high.
// RQ2: read data follows address changes and stays valid until control changes.
// RQ3: device writes when chip and write enable low; data taken at end.
// RQ4: host holds address stable across the whole write cycle.
// RQ5: device floats outputs during write; host keeps output enable high.
// RQ6: device latches recall at power-up and runs it above switch threshold.
// RQ7: power-up recall completes within 550 microseconds.
// RQ8: host presents no write condition when power-up recall ends.
// RQ9: six chip-enable reads ending 0FC0 start a software store.
// RQ10: six reads, same first five, ending 0C63 start a recall, low 14 bits compared.
// RQ11: host toggles chip enable per sequence access, write enable high throughout.
// RQ12: any other access between steps abandons the sequence.
// RQ13: sequence accepted with output enable either level; reads only.
// RQ14: after sixth address, store runs, access blocked up to 10 ms.
// RQ15: store erases nonvolatile copy, then programs it from SRAM.
// RQ16: during store or recall normal SRAM access is refused.
// RQ17: hardware store request holds store-busy low at least 20 ns.
// RQ18: device allows a running cycle at least 1 us before storing.
// RQ19: device drives store-busy low within 300 ns of request.
// RQ20: inhibit lifts within 700 ns after store-busy returns high.
// RQ21: supply loss drives store-busy low 1 us for automatic store.
// RQ22: with no write since last nonvolatile cycle, automatic store skipped.
// RQ23: device holds store-busy low for the whole store.
// RQ24: writes requested while store-busy low are blocked.
// RQ25: after store the device stays disabled until store-busy seen high.
// RQ26: software recall finishes within recall duration, then access resumes.
`timescale 1ns/1ps
`default_nettype none
module nvsc_ctrl #(
    parameter int STORE_WAIT_CYC   = nvsc_pkg::STORE_CYC,
    parameter int POWERUP_WAIT_CYC = nvsc_pkg::POWERUP_CYC
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // command port
    input  wire logic                   cmdValid,
    input  wire nvsc_pkg::nvsc_cmd_type cmd,
    output logic                        cmdReady,
    // answers and status
    output logic                        rspValid,
    output logic [7:0]                  rspData,
    output logic                        nvBusy,
    // memory pins
    output nvsc_pkg::nvsc_pin_type      pinOut,
    input  wire logic [7:0]             dataBusIn,
    input  wire logic                   storeBusyNIn
);
    import nvsc_pkg::*;

    typedef enum logic [3:0] {
        ST_PWRUP, ST_IDLE, ST_READ, ST_WSETUP, ST_WPULSE, ST_WHOLD,
        ST_SEQSETUP, ST_SEQPULSE, ST_NVWAIT, ST_HWREQ, ST_BUSYWAIT, ST_RECOVER
    } nvsc_state_type;

    localparam logic [CNT_W-1:0] CNT_READ  = CNT_W'(READ_CYC + SYNC_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_PULSE = CNT_W'(PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_REQ   = CNT_W'(REQ_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_REC   = CNT_W'(RECOVER_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_RCL   = CNT_W'(RECALL_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_STORE = CNT_W'(STORE_WAIT_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_PWRUP = CNT_W'(POWERUP_WAIT_CYC - 1);

    nvsc_state_type   state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [2:0]       seqIdx_ff, nxt_seqIdx;
    logic             recall_ff, nxt_recall;
    nvsc_pin_type     pin_ff, nxt_pin;
    logic             ready_ff, nxt_ready;
    logic             rspValid_ff, nxt_rspValid;
    logic [7:0]       rspData_ff, nxt_rspData;
    logic             nvBusy_ff, nxt_nvBusy;
    logic [7:0]       dataSync;
    logic             busySync;

    // pins come from outside the clock domain
    nvsc_sync #(.W(9), .RST_VAL(9'h100)) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn ({storeBusyNIn, dataBusIn}),
        .syncOut ({busySync, dataSync})
    );

    always_comb begin
        nxt_state    = state_ff;
        nxt_cnt      = (cnt_ff != '0) ? cnt_ff - CNT_W'(1) : cnt_ff;
        nxt_seqIdx   = seqIdx_ff;
        nxt_recall   = recall_ff;
        nxt_pin      = pin_ff;
        nxt_rspValid = 1'b0;
        nxt_rspData  = rspData_ff;
        unique case (state_ff)
            ST_PWRUP: begin
                // write enable stays high until recall is surely over
                nxt_pin.writeEnableN = 1'b1; // RQ8
                if (cnt_ff == '0) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // a command taken while ready is never dropped; device inhibits it
                if (cmdValid && ready_ff) begin
                    nxt_pin.addressBus = cmd.addr;
                    unique case (cmd.op)
                        OP_READ: begin
                            nxt_pin.chipEnableN   = 1'b0;
                            nxt_pin.outputEnableN = 1'b0;
                            nxt_cnt               = CNT_READ;
                            nxt_state             = ST_READ;
                        end
                        OP_WRITE: begin
                            // address and data settle before enables fall
                            nxt_pin.dataBusOut = cmd.wdata;
                            nxt_pin.dataBusOe  = 1'b1;
                            nxt_state          = ST_WSETUP; // RQ4
                        end
                        OP_SW_STORE, OP_SW_RECALL: begin
                            nxt_recall         = (cmd.op == OP_SW_RECALL);
                            nxt_seqIdx         = 3'h0;
                            nxt_pin.addressBus = seqAddr(3'h0, cmd.op == OP_SW_RECALL);
                            nxt_state          = ST_SEQSETUP;
                        end
                        OP_HW_STORE: begin
                            nxt_pin.storeBusyNOe = 1'b1; // RQ17
                            nxt_cnt              = CNT_REQ;
                            nxt_state            = ST_HWREQ;
                        end
                        default: begin
                            nxt_state = ST_IDLE;
                        end
                    endcase
                end else if (!busySync) begin
                    // store in progress: keep off the bus until it ends
                    nxt_state = ST_BUSYWAIT; // RQ24
                end
            end
            ST_READ: begin
                // wait covers access time plus synchroniser latency
                if (cnt_ff == '0) begin
                    nxt_rspData           = dataSync;
                    nxt_rspValid          = 1'b1;
                    nxt_pin.chipEnableN   = 1'b1;
                    nxt_pin.outputEnableN = 1'b1;
                    nxt_state             = ST_IDLE;
                end
            end
            ST_WSETUP: begin
                nxt_pin.chipEnableN  = 1'b0;
                nxt_pin.writeEnableN = 1'b0;
                nxt_cnt              = CNT_PULSE;
                nxt_state            = ST_WPULSE;
            end
            ST_WPULSE: begin
                if (cnt_ff == '0) begin
                    nxt_pin.chipEnableN  = 1'b1;
                    nxt_pin.writeEnableN = 1'b1;
                    nxt_state            = ST_WHOLD;
                end
            end
            ST_WHOLD: begin
                // data and address held one cycle past the rising enables
                nxt_pin.dataBusOe = 1'b0; // RQ4
                nxt_rspValid      = 1'b1;
                nxt_state         = ST_IDLE;
            end
            ST_SEQSETUP: begin
                // each step is its own chip-enable pulse, write enable high
                nxt_pin.chipEnableN  = 1'b0; // RQ11
                nxt_pin.writeEnableN = 1'b1; // RQ11
                nxt_cnt              = CNT_PULSE;
                nxt_state            = ST_SEQPULSE;
            end
            ST_SEQPULSE: begin
                if (cnt_ff == '0) begin
                    nxt_pin.chipEnableN = 1'b1; // RQ11
                    if (seqIdx_ff == SEQ_LAST) begin
                        nxt_cnt   = recall_ff ? CNT_RCL : CNT_STORE; // RQ14 RQ26
                        nxt_state = ST_NVWAIT;
                    end else begin
                        nxt_seqIdx         = seqIdx_ff + 3'h1;
                        nxt_pin.addressBus = seqAddr(seqIdx_ff + 3'h1, recall_ff); // RQ9 RQ10
                        nxt_state          = ST_SEQSETUP;
                    end
                end
            end
            ST_NVWAIT: begin
                // device refuses access for the whole nonvolatile cycle
                if (cnt_ff == '0) begin
                    nxt_state = ST_BUSYWAIT; // RQ16
                end
            end
            ST_HWREQ: begin
                // held past the busy response time, then the pin is let go
                if (cnt_ff == '0) begin
                    nxt_pin.storeBusyNOe = 1'b0; // RQ17
                    nxt_state            = ST_BUSYWAIT;
                end
            end
            ST_BUSYWAIT: begin
                if (busySync && !pin_ff.storeBusyNOe) begin
                    nxt_cnt   = CNT_REC; // RQ25
                    nxt_state = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (!busySync) begin
                    nxt_state = ST_BUSYWAIT;
                end else if (cnt_ff == '0) begin
                    nxt_state = ST_IDLE; // RQ20
                end
            end
        endcase
        nxt_ready  = (nxt_state == ST_IDLE) && busySync && !(cmdValid && ready_ff);
        nxt_nvBusy = !(nxt_state inside {ST_IDLE, ST_READ, ST_WSETUP, ST_WPULSE, ST_WHOLD});
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff    <= ST_PWRUP;
            cnt_ff      <= CNT_PWRUP;
            seqIdx_ff   <= 3'h0;
            recall_ff   <= 1'b0;
            pin_ff      <= PIN_RST;
            ready_ff    <= 1'b0;
            rspValid_ff <= 1'b0;
            rspData_ff  <= DATA_RST;
            nvBusy_ff   <= 1'b1;
        end else begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            seqIdx_ff   <= nxt_seqIdx;
            recall_ff   <= nxt_recall;
            pin_ff      <= nxt_pin;
            ready_ff    <= nxt_ready;
            rspValid_ff <= nxt_rspValid;
            rspData_ff  <= nxt_rspData;
            nvBusy_ff   <= nxt_nvBusy;
        end
    end

    assign pinOut   = pin_ff;
    assign cmdReady = ready_ff;
    assign rspValid = rspValid_ff;
    assign rspData  = rspData_ff;
    assign nvBusy   = nvBusy_ff;

    AST_WRITE_ADDR_STABLE: assert property (@(posedge clk_sys) disable iff (rst) // RQ4
        (!pin_ff.writeEnableN && !pin_ff.chipEnableN) |=> $stable(pin_ff.addressBus))
        else $error("address moved while write enables were low");

    AST_NO_WRITE_IN_PWRUP: assert property (@(posedge clk_sys) disable iff (rst) // RQ8
        (state_ff == ST_PWRUP) |-> (pin_ff.writeEnableN && pin_ff.chipEnableN))
        else $error("write condition present during power-up recall");

    AST_SEQ_WE_HIGH: assert property (@(posedge clk_sys) disable iff (rst) // RQ11
        (state_ff inside {ST_SEQSETUP, ST_SEQPULSE}) |-> pin_ff.writeEnableN)
        else $error("write enable low inside the software sequence");

    AST_SEQ_CE_TOGGLE: assert property (@(posedge clk_sys) disable iff (rst) // RQ11
        (state_ff == ST_SEQSETUP) |=> $fell(pin_ff.chipEnableN) ##1 pin_ff.chipEnableN)
        else $error("sequence step not framed by one chip-enable pulse");

    AST_HW_PULSE_WIDTH: assert property (@(posedge clk_sys) disable iff (rst) // RQ17
        $rose(pin_ff.storeBusyNOe) |-> pin_ff.storeBusyNOe[*8] ##1 !pin_ff.storeBusyNOe)
        else $error("store request pulse of wrong length");

    COV_READ:   cover property (@(posedge clk_sys) disable iff (rst) rspValid_ff && pin_ff.writeEnableN);
    COV_WRITE:  cover property (@(posedge clk_sys) disable iff (rst) state_ff == ST_WHOLD);
    COV_SEQ:    cover property (@(posedge clk_sys) disable iff (rst)
        state_ff == ST_SEQPULSE && seqIdx_ff == SEQ_LAST);
    COV_HWBUSY: cover property (@(posedge clk_sys) disable iff (rst)
        state_ff == ST_BUSYWAIT && !busySync);
endmodule : nvsc_ctrl
`default_nettype wire

// ---- verif/nvsc_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvsc_dev_model #(
    parameter int STORE_NS  = 600,
    parameter int RECALL_NS = 15000,
    parameter int BOOT_NS   = 300
) (
    // control pins, active low
    input  wire logic        ceN,
    input  wire logic        oeN,
    input  wire logic        weN,
    input  wire logic        hsbN,
    // address and resolved data bus
    input  wire logic [14:0] addr,
    input  wire logic [7:0]  dq,
    // supply loss event
    input  wire logic        supplyLoss,
    // device drive
    output logic      [7:0]  qOut,
    output logic             qOe,
    output logic             busyDrv
);
    localparam logic [13:0] SEQ_TAB [6] = '{14'h0E38, 14'h31C7, 14'h03E0,
                                           14'h3C1F, 14'h303F, 14'h0FC0};
    logic [7:0] mem [32768];
    logic [7:0] nv  [32768];
    logic       nvMode  = 1'b1;
    logic       written = 1'b0;
    logic       wrOn    = 1'b0;
    logic       ceWas   = 1'b1;
    logic [13:0] ceAddr = '0;
    int         idx     = 0;

    assign qOe  = !ceN && !oeN && weN && hsbN && !nvMode;
    assign qOut = mem[addr];

    task automatic nvCycle(input logic store);
        nvMode  = 1'b1;
        busyDrv = store;
        #(store ? STORE_NS : RECALL_NS);
        if (store) nv = mem;
        else mem = nv;
        written = 1'b0;
        busyDrv = 1'b0;
        // stays disabled until the shared pin is seen high
        wait (hsbN === 1'b1);
        nvMode = 1'b0;
    endtask : nvCycle

    initial begin
        busyDrv = 1'b0;
        for (int i = 0; i < 32768; i++) nv[i] = i[7:0] ^ 8'hA5;
        #(BOOT_NS);
        mem = nv;
        nvMode = 1'b0;
    end

    always @(ceN or weN) begin
        logic rise;
        // pins of one edge arrive in any order; look once they settle
        #0.2;
        rise  = ceN && !ceWas;
        // sequence address is taken as chip enable falls, host moves it at the rise
        if (!ceN && ceWas) ceAddr = addr[13:0];
        ceWas = ceN;
        if (!ceN && !weN) wrOn = 1'b1;
        else if (wrOn) begin
            wrOn = 1'b0;
            idx  = 0;
            if (hsbN && !nvMode) begin
                mem[addr] = dq;
                written   = 1'b1;
            end
        end else if (rise && weN && !nvMode) begin
            if (ceAddr == SEQ_TAB[idx]) idx++;
            else if (idx == 5 && ceAddr == 14'h0C63) idx = 7;
            else idx = (ceAddr == SEQ_TAB[0]) ? 1 : 0;
            if (idx >= 6) begin
                nvCycle(idx == 6);
                idx = 0;
            end
        end
    end

    // a requested store needs a write since the last cycle
    always @(negedge hsbN) begin
        if (!busyDrv && !nvMode && written) begin
            #200 busyDrv = 1'b1;
            #800 nvCycle(1'b1);
        end
    end

    always @(posedge supplyLoss) begin
        busyDrv = 1'b1;
        #1000;
        if (written) nvCycle(1'b1);
        else busyDrv = 1'b0;
    end
endmodule : nvsc_dev_model
`default_nettype wire

// ---- verif/nvsc_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvsc_ctrl_tb;
    import nvsc_pkg::*;
    localparam int STORE_WAIT = 20;
    localparam int LIMIT      = 60000;
    localparam int SEQ_A [5]  = '{'h0E38, 'h31C7, 'h03E0, 'h3C1F, 'h303F};
    logic         clk_sys     = 1'b0;
    logic         rst         = 1'b1;
    logic         cmdValid    = 1'b0;
    logic         supplyLoss  = 1'b0;
    nvsc_cmd_type cmd         = '0;
    logic         cmdReady, rspValid, nvBusy, devOe, devBusy, hsbN;
    logic [7:0]   rspData, devQ, dataBus;
    logic [7:0]   busLast     = 8'h00;
    nvsc_pin_type pinOut;
    int           refMem [32768];
    int           refNv [32768];
    bit           refWritten  = 1'b0;
    int           nMismatch   = 0;
    int           comparisons = 0;
    int           cyc         = 0;

    // released bus shows the inverse of its last value, never a stale copy
    assign dataBus = pinOut.dataBusOe ? pinOut.dataBusOut : (devOe ? devQ : ~busLast);
    assign hsbN    = !(pinOut.storeBusyNOe && !pinOut.storeBusyNOut) && !devBusy;

    nvsc_ctrl #(.STORE_WAIT_CYC(STORE_WAIT), .POWERUP_WAIT_CYC(10)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid), .cmd(cmd),
        .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .nvBusy(nvBusy),
        .pinOut(pinOut), .dataBusIn(dataBus), .storeBusyNIn(hsbN));

    nvsc_dev_model #(.STORE_NS(STORE_WAIT * 40 - 200)) i_dev (
        .ceN(pinOut.chipEnableN), .oeN(pinOut.outputEnableN), .weN(pinOut.writeEnableN),
        .hsbN(hsbN), .addr(pinOut.addressBus), .dq(dataBus), .supplyLoss(supplyLoss),
        .qOut(devQ), .qOe(devOe), .busyDrv(devBusy));

    initial forever #20 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        busLast <= dataBus;
        cyc++;
        if (cyc == LIMIT) begin
            nMismatch++;
            conclude();
        end
    end

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", nMismatch, comparisons);
        if (nMismatch == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    task automatic checkByte(input string what, input int exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp[7:0]) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp[7:0], got);
        end
    endtask : checkByte

    task automatic checkBit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : checkBit

    // entered and left 1 ns after a rising edge
    task automatic issue(input nvsc_op_type op, input int a, input int d);
        cmdValid = 1'b1;
        cmd      = '{op, a[14:0], d[7:0]};
        // cmdReady as it stands now is what the next edge takes
        while (cmdReady !== 1'b1) begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        #1;
        cmdValid = 1'b0;
        if (op == OP_READ || op == OP_WRITE) begin
            do begin
                @(posedge clk_sys);
                #1;
            end while (rspValid !== 1'b1);
        end else begin
            @(posedge clk_sys);
            #1;
            checkBit("nvBusy", 1'b1, nvBusy);
        end
    endtask : issue

    task automatic rd(input int a);
        issue(OP_READ, a, 0);
        checkByte("read data", refMem[a], rspData);
    endtask : rd

    task automatic wr(input int a, input int d);
        issue(OP_WRITE, a, d);
        refMem[a]  = d;
        refWritten = 1'b1;
    endtask : wr

    task automatic refStore(input bit sw);
        if (sw || refWritten) refNv = refMem;
        refWritten = 1'b0;
    endtask : refStore

    task automatic recall();
        issue(OP_SW_RECALL, 0, 0);
        refMem     = refNv;
        refWritten = 1'b0;
    endtask : recall

    task automatic waitFree();
        while (hsbN !== 1'b1) begin
            @(posedge clk_sys);
            #1;
        end
    endtask : waitFree

    initial begin
        int a;
        void'($urandom(47369));
        for (int i = 0; i < 32768; i++) refNv[i] = (i & 255) ^ 'hA5;
        refMem = refNv;
        repeat (10) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 4; i++) rd($urandom_range(32767));
        for (int i = 0; i < 24; i++) begin
            a = $urandom_range(32767);
            wr(a, $urandom_range(255));
            rd(a);
            rd($urandom_range(32767));
        end
        issue(OP_SW_STORE, 0, 0);
        refStore(1'b1);
        wr(a, 'h3C);
        recall();
        rd(a);
        for (int k = 0; k < 2; k++) begin
            wr(a, 'h5A + k);
            for (int s = 0; s < 5; s++) rd(SEQ_A[s]);
            if (k == 0) rd('h0123);
            if (k == 0) rd('h0FC0);
            else issue(OP_READ, 'h0FC0, 0);
            waitFree();
            if (k == 1) refStore(1'b1);
            recall();
            rd(a);
        end
        wr(a, 'hC3);
        issue(OP_HW_STORE, 0, 0);
        refStore(1'b0);
        wr(a, 'h11);
        rd(a);
        recall();
        rd(a);
        for (int k = 0; k < 2; k++) begin
            if (k == 1) wr(a, 'h77);
            supplyLoss = 1'b1;
            repeat (20) @(posedge clk_sys);
            #1;
            checkBit("cmdReady while busy", 1'b0, cmdReady);
            supplyLoss = 1'b0;
            waitFree();
            refStore(1'b0);
            wr(a, 'h99);
            recall();
            rd(a);
        end
        conclude();
    end
endmodule : nvsc_ctrl_tb
`default_nettype wire
